/* File: hdl/pbc_config_regs.sv */
// Configuration register bank of one PCI port of the expander bridge
//
// Overview of operation
// R1: Time slice count sits in bits 7:3; each step is eight PCI clocks.
// R2: Time slice bits 2:0 read zero and count as zero.
// R3: After expiry, finish data phase, release when grant goes.
// R4: Parity enable drives PERR# on data parity errors; clear reports none.
// R5: Address parity errors go only to SERR#, needing both enables.
// R6: Command bit 4 permits Memory Write and Invalidate; resets to one.
// R7: Command bit 7, stepping, is wired to zero.
// R8: Command bit 3 is wired to zero; special cycles are ignored.
// R9: Command bits 2 and 1 are wired to one.
// R10: Command bit 0 is wired zero; I/O cycles never claimed.
// R11: Status bit 15 sets on any detected data or address parity error.
// R12: Status bit 14 sets whenever SERR# is asserted.
// R13: Status bit 13 sets on own master abort, not special cycles.
// R14: Status bit 12 sets on target abort of own transaction.
// R15: Status bit 11 sets when device as target signals target abort.
// R16: Status bit 8 needs PERR# seen, own initiation and parity enable.
// R17: Error flags stay set until software writes one; zero leaves them.
// R18: Status bits 10:9 read fixed 01b, medium select timing.
// R19: Status bit 7 reads one; bits 6 and 5 read zero.
// R20: 1 MB APIC window at its base decodes inbound accesses.
// R21: Seven attribute registers, 14 segments; first resets 03h.
// R22: Mapped base and top bound the second segment range.
// R23: Software mirrors decode registers in the host controller.
// R24: In 64-bit mode only the first port's space is reachable.
// R25: Slice loads on ownership, counts PCI clocks, expires at zero.
`default_nettype none
module pbc_config_regs #(
	parameter logic [15:0] VENDOR_IDENT = 16'h1234, // Arbitrary value
	parameter logic [15:0] DEVICE_IDENT = 16'h5678 // Arbitrary value
) (
	input wire logic clock_in,
	input wire logic rst_in,
	// Configuration access port, dword wide with byte enables
	input wire logic cfg_read_in,
	input wire logic cfg_write_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_byte_en_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_rvalid_out,
	// Straps
	input wire logic mode64_n_in,
	input wire logic second_port_in,
	// PCI side, sampled by clock_in through a two-flop synchroniser
	input wire logic pci_clk_in,
	input wire logic gnt_n_in,
	input wire logic data_parity_err_in,
	input wire logic addr_parity_err_in,
	input wire logic perr_n_in,
	input wire logic master_abort_in,
	input wire logic special_cycle_in,
	input wire logic target_abort_rcvd_in,
	input wire logic target_abort_sent_in,
	input wire logic initiator_in,
	output logic perr_n_out,
	output logic perr_n_oe_out,
	output logic serr_n_out,
	output logic serr_n_oe_out,
	// Own master engine
	input wire logic bus_owned_in,
	input wire logic data_phase_done_in,
	output logic slice_expired_out,
	output logic release_bus_out,
	output logic mwi_enable_out,
	output logic claim_io_out,
	output logic claim_special_out,
	// Inbound address decode
	input wire logic [31:0] inbound_addr_in,
	output logic apic_hit_out,
	output logic low_gap_hit_out,
	output logic mapped_pci_hit_out,
	output logic [8*pbc_pkg::SEG_REGS-1:0] segment_attrs_out,
	output logic [7:0] legacy_space_window_out
);
	localparam int NSYNC = 10;

	logic [NSYNC-1:0] raw_pins;
	logic [NSYNC-1:0] pins;
	logic pci_clk_s;
	logic gnt_n_s;
	logic data_par_s;
	logic addr_par_s;
	logic perr_n_s;
	logic mabort_s;
	logic special_s;
	logic tabort_rcvd_s;
	logic tabort_sent_s;
	logic initiator_s;
	logic pci_clk_prev;
	logic pci_tick;

	// Pins pass two flops first
	assign raw_pins = {pci_clk_in, gnt_n_in, data_parity_err_in, addr_parity_err_in, perr_n_in,
		master_abort_in, special_cycle_in, target_abort_rcvd_in, target_abort_sent_in, initiator_in};

	pbc_sync #(
		.WIDTH(NSYNC)
	) u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in(raw_pins),
		.sync_out(pins)
	);

	assign {pci_clk_s, gnt_n_s, data_par_s, addr_par_s, perr_n_s,
		mabort_s, special_s, tabort_rcvd_s, tabort_sent_s, initiator_s} = pins;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pci_clk_prev <= 1'b0;
		end else begin
			pci_clk_prev <= pci_clk_s;
		end
	end

	// One enable per PCI rising edge
	assign pci_tick = pci_clk_s && !pci_clk_prev;

	// Strap capture after reset release
	logic strap_taken;
	logic wide_mode;
	logic is_second;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			strap_taken <= 1'b0;
			wide_mode <= 1'b0;
			is_second <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			wide_mode <= !mode64_n_in;
			is_second <= second_port_in;
		end
	end

	// Registers
	logic [15:0] command;
	logic [15:0] status;
	logic [7:0] slice;
	logic [15:0] gap_base;
	logic [15:0] gap_top;
	logic [15:0] apic_base;
	logic [15:0] mapped_base;
	logic [15:0] mapped_top;
	logic [7:0] legacy;
	logic [7:0] seg_attr [pbc_pkg::SEG_REGS];

	// Access decode
	logic space_open;
	logic wr_ok;
	logic [5:0] dword;
	logic [3:0] lane_wr;

	assign space_open = !(wide_mode && is_second); // R24
	assign wr_ok = cfg_write_in && space_open;
	assign dword = cfg_addr_in[7:2];
	assign lane_wr = wr_ok ? cfg_byte_en_in : 4'h0;

	function automatic logic byte_hit(input logic [7:0] ofs, input logic [5:0] dw, input logic [3:0] lanes);
		byte_hit = (dw == ofs[7:2]) && lanes[ofs[1:0]];
	endfunction : byte_hit

	function automatic logic [7:0] byte_of(input logic [7:0] ofs, input logic [31:0] data);
		byte_of = data[8*ofs[1:0] +: 8];
	endfunction : byte_of

	// Byte strobes for every writable byte except the attribute bytes
	logic cmd_lo_we;
	logic cmd_hi_we;
	logic sts_lo_we;
	logic sts_hi_we;
	logic slice_we;
	logic gap_base_lo_we;
	logic gap_base_hi_we;
	logic gap_top_lo_we;
	logic gap_top_hi_we;
	logic apic_lo_we;
	logic apic_hi_we;
	logic mapped_base_lo_we;
	logic mapped_base_hi_we;
	logic mapped_top_lo_we;
	logic mapped_top_hi_we;
	logic legacy_we;

	assign cmd_lo_we = byte_hit(pbc_pkg::OFS_COMMAND, dword, lane_wr);
	assign cmd_hi_we = byte_hit(pbc_pkg::OFS_COMMAND + 8'h01, dword, lane_wr);
	assign sts_lo_we = byte_hit(pbc_pkg::OFS_STATUS, dword, lane_wr);
	assign sts_hi_we = byte_hit(pbc_pkg::OFS_STATUS + 8'h01, dword, lane_wr);
	assign slice_we = byte_hit(pbc_pkg::OFS_SLICE, dword, lane_wr);
	assign gap_base_lo_we = byte_hit(pbc_pkg::OFS_GAP_BASE, dword, lane_wr);
	assign gap_base_hi_we = byte_hit(pbc_pkg::OFS_GAP_BASE + 8'h01, dword, lane_wr);
	assign gap_top_lo_we = byte_hit(pbc_pkg::OFS_GAP_TOP, dword, lane_wr);
	assign gap_top_hi_we = byte_hit(pbc_pkg::OFS_GAP_TOP + 8'h01, dword, lane_wr);
	assign apic_lo_we = byte_hit(pbc_pkg::OFS_APIC_BASE, dword, lane_wr);
	assign apic_hi_we = byte_hit(pbc_pkg::OFS_APIC_BASE + 8'h01, dword, lane_wr);
	assign mapped_base_lo_we = byte_hit(pbc_pkg::OFS_MAPPED_BASE, dword, lane_wr);
	assign mapped_base_hi_we = byte_hit(pbc_pkg::OFS_MAPPED_BASE + 8'h01, dword, lane_wr);
	assign mapped_top_lo_we = byte_hit(pbc_pkg::OFS_MAPPED_TOP, dword, lane_wr);
	assign mapped_top_hi_we = byte_hit(pbc_pkg::OFS_MAPPED_TOP + 8'h01, dword, lane_wr);
	assign legacy_we = byte_hit(pbc_pkg::OFS_LEGACY, dword, lane_wr);

	// Only enables writable, rest wired
	logic [15:0] cmd_written;
	logic [15:0] next_command;

	assign cmd_written = {cmd_hi_we ? byte_of(pbc_pkg::OFS_COMMAND + 8'h01, cfg_wdata_in) : command[15:8],
		cmd_lo_we ? byte_of(pbc_pkg::OFS_COMMAND, cfg_wdata_in) : command[7:0]};
	assign next_command = (cmd_written & pbc_pkg::CMD_WRITABLE) | pbc_pkg::CMD_FIXED_ONES; // R7 R8 R9 R10

	logic perr_enable;
	logic serr_enable;

	assign perr_enable = command[pbc_pkg::CMD_PARITY];
	assign serr_enable = command[pbc_pkg::CMD_SYSERR];
	assign mwi_enable_out = command[pbc_pkg::CMD_MWI]; // R6
	assign claim_io_out = command[pbc_pkg::CMD_IO]; // R10
	assign claim_special_out = command[pbc_pkg::CMD_SPECIAL]; // R8

	// Error signalling, each pin held for one PCI clock
	logic drive_perr;
	logic drive_serr;
	logic next_drive_perr;
	logic next_drive_serr;

	assign next_drive_perr = data_par_s && perr_enable; // R4
	assign next_drive_serr = addr_par_s && perr_enable && serr_enable; // R5

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			drive_perr <= 1'b0;
			drive_serr <= 1'b0;
		end else if (pci_tick) begin
			drive_perr <= next_drive_perr; // R4
			drive_serr <= next_drive_serr; // R5
		end
	end

	// Open drain: drive low, enable low while driving
	assign perr_n_out = 1'b0;
	assign perr_n_oe_out = !drive_perr;
	assign serr_n_out = 1'b0;
	assign serr_n_oe_out = !drive_serr;

	// Status events, one per PCI clock edge
	logic [15:0] sts_set;
	logic [15:0] sts_clear;
	logic perr_active;

	assign perr_active = drive_perr || !perr_n_s;

	always_comb begin
		sts_set = 16'h0000;
		sts_set[pbc_pkg::STS_PE] = pci_tick && (data_par_s || addr_par_s); // R11
		sts_set[pbc_pkg::STS_SSE] = pci_tick && next_drive_serr; // R12
		sts_set[pbc_pkg::STS_RMA] = pci_tick && mabort_s && !special_s; // R13
		sts_set[pbc_pkg::STS_RTA] = pci_tick && tabort_rcvd_s; // R14
		sts_set[pbc_pkg::STS_STA] = pci_tick && tabort_sent_s; // R15
		sts_set[pbc_pkg::STS_MDPE] = pci_tick && perr_active && initiator_s && perr_enable; // R16
	end

	assign sts_clear = {sts_hi_we ? byte_of(pbc_pkg::OFS_STATUS + 8'h01, cfg_wdata_in) : 8'h00,
		sts_lo_we ? byte_of(pbc_pkg::OFS_STATUS, cfg_wdata_in) : 8'h00} & pbc_pkg::STS_STICKY;

	// Set wins over a clear in the same cycle
	logic [15:0] next_status;

	assign next_status = ((status & ~sts_clear) | sts_set) & pbc_pkg::STS_STICKY; // R17

	// Command, status, slice and legacy registers
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			command <= pbc_pkg::RST_COMMAND; // R6
			status <= pbc_pkg::RST_STATUS & pbc_pkg::STS_STICKY;
			slice <= pbc_pkg::RST_SLICE;
			legacy <= pbc_pkg::RST_LEGACY;
		end else begin
			command <= next_command;
			status <= next_status; // R17
			if (slice_we) begin
				slice <= byte_of(pbc_pkg::OFS_SLICE, cfg_wdata_in) & pbc_pkg::SLICE_MASK; // R2
			end
			if (legacy_we) begin
				legacy <= byte_of(pbc_pkg::OFS_LEGACY, cfg_wdata_in);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			gap_base <= pbc_pkg::RST_GAP;
			gap_top <= pbc_pkg::RST_GAP;
			apic_base <= pbc_pkg::RST_APIC_BASE;
			mapped_base <= pbc_pkg::RST_MAPPED_BASE;
			mapped_top <= pbc_pkg::RST_MAPPED_TOP;
		end else begin
			if (gap_base_lo_we) gap_base[7:0] <= byte_of(pbc_pkg::OFS_GAP_BASE, cfg_wdata_in);
			if (gap_base_hi_we) gap_base[15:8] <= byte_of(pbc_pkg::OFS_GAP_BASE + 8'h01, cfg_wdata_in);
			if (gap_top_lo_we) gap_top[7:0] <= byte_of(pbc_pkg::OFS_GAP_TOP, cfg_wdata_in);
			if (gap_top_hi_we) gap_top[15:8] <= byte_of(pbc_pkg::OFS_GAP_TOP + 8'h01, cfg_wdata_in);
			if (apic_lo_we) apic_base[7:0] <= byte_of(pbc_pkg::OFS_APIC_BASE, cfg_wdata_in);
			if (apic_hi_we) apic_base[15:8] <= byte_of(pbc_pkg::OFS_APIC_BASE + 8'h01, cfg_wdata_in);
			if (mapped_base_lo_we) mapped_base[7:0] <= byte_of(pbc_pkg::OFS_MAPPED_BASE, cfg_wdata_in);
			if (mapped_base_hi_we) mapped_base[15:8] <= byte_of(pbc_pkg::OFS_MAPPED_BASE + 8'h01, cfg_wdata_in);
			if (mapped_top_lo_we) mapped_top[7:0] <= byte_of(pbc_pkg::OFS_MAPPED_TOP, cfg_wdata_in);
			if (mapped_top_hi_we) mapped_top[15:8] <= byte_of(pbc_pkg::OFS_MAPPED_TOP + 8'h01, cfg_wdata_in);
		end
	end

	// Attribute bytes, two segments each
	logic [31:0] seg_dword [2];

	generate
		for (genvar i = 0; i < pbc_pkg::SEG_REGS; i++) begin : g_seg
			localparam logic [7:0] OFS = pbc_pkg::OFS_SEG_ATTR + 8'(i);
			logic seg_we;

			assign seg_we = byte_hit(OFS, dword, lane_wr);
			assign segment_attrs_out[8*i +: 8] = seg_attr[i];

			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					seg_attr[i] <= (i == 0) ? pbc_pkg::RST_SEG_FIRST : pbc_pkg::RST_SEG_OTHER; // R21
				end else if (seg_we) begin
					seg_attr[i] <= byte_of(OFS, cfg_wdata_in); // R21
				end
			end
		end
	endgenerate

	assign seg_dword[0] = {seg_attr[2], seg_attr[1], seg_attr[0], 8'h00};
	assign seg_dword[1] = {seg_attr[6], seg_attr[5], seg_attr[4], seg_attr[3]};

	// Read data selection
	logic [31:0] rd_word;
	logic [31:0] status_word;
	logic [15:0] status_view;

	assign status_view = status | pbc_pkg::STS_FIXED; // R18 R19
	assign status_word = {status_view, command};
	assign rd_word = !space_open ? 32'h0000_0000 : // R24
		(dword == pbc_pkg::OFS_IDENT[7:2]) ? {DEVICE_IDENT, VENDOR_IDENT} :
		(dword == pbc_pkg::OFS_COMMAND[7:2]) ? status_word :
		(dword == pbc_pkg::OFS_SLICE[7:2]) ? {16'h0000, slice, 8'h00} : // R2
		(dword == pbc_pkg::OFS_GAP_BASE[7:2]) ? {gap_top, gap_base} :
		(dword == pbc_pkg::OFS_SEG_ATTR[7:2]) ? seg_dword[0] :
		(dword == pbc_pkg::OFS_SEG_ATTR[7:2] + 6'h01) ? seg_dword[1] :
		(dword == pbc_pkg::OFS_APIC_BASE[7:2]) ? {16'h0000, apic_base} :
		(dword == pbc_pkg::OFS_MAPPED_BASE[7:2]) ? {16'h0000, mapped_base} :
		(dword == pbc_pkg::OFS_MAPPED_TOP[7:2]) ? {16'h0000, mapped_top} :
		(dword == pbc_pkg::OFS_LEGACY[7:2]) ? {24'h000000, legacy} :
		32'h0000_0000;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cfg_rdata_out <= 32'h0000_0000;
			cfg_rvalid_out <= 1'b0;
		end else begin
			cfg_rvalid_out <= cfg_read_in;
			if (cfg_read_in) begin
				cfg_rdata_out <= rd_word;
			end
		end
	end

	// Field times eight is the clock count
	logic [7:0] slice_clocks;
	logic slice_done;

	assign slice_clocks = slice & pbc_pkg::SLICE_MASK; // R1 R2

	pbc_slice_timer #(
		.WIDTH(8)
	) u_timer (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.tick_in(pci_tick),
		.owner_in(bus_owned_in),
		.count_in(slice_clocks),
		.expired_out(slice_done),
		.count_out()
	);

	assign slice_expired_out = slice_done; // R25
	// Surrender only after data phase and grant loss
	assign release_bus_out = slice_done && gnt_n_s && data_phase_done_in; // R3

	// Inbound decode windows, registered
	logic [pbc_pkg::WIN_BITS-1:0] granule;
	logic next_apic_hit;
	logic next_gap_hit;
	logic next_mapped_hit;

	assign granule = inbound_addr_in[pbc_pkg::WIN_LSB +: pbc_pkg::WIN_BITS];
	assign next_apic_hit = granule == apic_base[pbc_pkg::WIN_BITS-1:0]; // R20
	assign next_gap_hit = (granule >= gap_base[pbc_pkg::WIN_BITS-1:0]) &&
		(granule <= gap_top[pbc_pkg::WIN_BITS-1:0]) && (gap_top >= gap_base);
	assign next_mapped_hit = (granule >= mapped_base[pbc_pkg::WIN_BITS-1:0]) &&
		(granule <= mapped_top[pbc_pkg::WIN_BITS-1:0]); // R22

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			apic_hit_out <= 1'b0;
			low_gap_hit_out <= 1'b0;
			mapped_pci_hit_out <= 1'b0;
			legacy_space_window_out <= pbc_pkg::RST_LEGACY;
		end else begin
			apic_hit_out <= next_apic_hit; // R20
			low_gap_hit_out <= next_gap_hit;
			mapped_pci_hit_out <= next_mapped_hit; // R22
			legacy_space_window_out <= legacy;
		end
	end
endmodule : pbc_config_regs
`default_nettype wire

/* File: hdl/pbc_pkg.sv */
// Constants shared by the PCI port configuration register bank
`default_nettype none
package pbc_pkg;
	// Byte offsets inside one port's configuration space
	localparam logic [7:0] OFS_IDENT = 8'h00;
	localparam logic [7:0] OFS_COMMAND = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h06;
	localparam logic [7:0] OFS_SLICE = 8'h0d;
	localparam logic [7:0] OFS_GAP_BASE = 8'h54;
	localparam logic [7:0] OFS_GAP_TOP = 8'h56;
	localparam logic [7:0] OFS_SEG_ATTR = 8'h61;
	localparam logic [7:0] OFS_APIC_BASE = 8'h68;
	localparam logic [7:0] OFS_MAPPED_BASE = 8'h70;
	localparam logic [7:0] OFS_MAPPED_TOP = 8'h78;
	localparam logic [7:0] OFS_LEGACY = 8'h7c;

	localparam int SEG_REGS = 7;
	localparam int SEG_COUNT = 14;

	// Reset values
	localparam logic [15:0] RST_COMMAND = 16'h0016;
	localparam logic [15:0] RST_STATUS = 16'h0280;
	localparam logic [7:0] RST_SLICE = 8'h00;
	localparam logic [15:0] RST_GAP = 16'h0000;
	localparam logic [7:0] RST_SEG_FIRST = 8'h03;
	localparam logic [7:0] RST_SEG_OTHER = 8'h00;
	localparam logic [15:0] RST_APIC_BASE = 16'h0fec;
	localparam logic [15:0] RST_MAPPED_BASE = 16'h0002;
	localparam logic [15:0] RST_MAPPED_TOP = 16'h0000;
	localparam logic [7:0] RST_LEGACY = 8'h00;

	// Command bits
	localparam int CMD_IO = 0;
	localparam int CMD_MEM = 1;
	localparam int CMD_MASTER = 2;
	localparam int CMD_SPECIAL = 3;
	localparam int CMD_MWI = 4;
	localparam int CMD_PARITY = 6;
	localparam int CMD_STEPPING = 7;
	localparam int CMD_SYSERR = 8;
	// Bits software may change; the rest are wired
	localparam logic [15:0] CMD_WRITABLE = 16'h0150;
	localparam logic [15:0] CMD_FIXED_ONES = 16'h0006;

	// Status bits
	localparam int STS_MDPE = 8;
	localparam int STS_STA = 11;
	localparam int STS_RTA = 12;
	localparam int STS_RMA = 13;
	localparam int STS_SSE = 14;
	localparam int STS_PE = 15;
	localparam logic [15:0] STS_FIXED = 16'h0280;
	localparam logic [15:0] STS_STICKY = 16'hf900;

	// Time slice: count field and its unit in PCI clocks
	localparam logic [7:0] SLICE_MASK = 8'hf8;
	localparam int SLICE_UNIT_CLOCKS = 8;

	// Decode windows compare address bits 31:20 (1 MB granules)
	localparam int WIN_LSB = 20;
	localparam int WIN_BITS = 12;
endpackage : pbc_pkg
`default_nettype wire

/* File: hdl/pbc_slice_timer.sv */
// Master time-slice counter, one step per PCI clock
`default_nettype none
module pbc_slice_timer #(
	parameter int WIDTH = 8
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic owner_in,
	input wire logic [WIDTH-1:0] count_in,
	output logic expired_out,
	output logic [WIDTH-1:0] count_out
);
	typedef enum logic [2:0] {
		PBC_IDLE = 3'b001,
		PBC_RUN = 3'b010,
		PBC_DONE = 3'b100
	} pbc_slice_state_t;

	pbc_slice_state_t state;
	pbc_slice_state_t next_state;
	logic owner_prev;
	logic gained;
	logic [WIDTH-1:0] next_count;

	assign gained = owner_in && !owner_prev;
	assign expired_out = (state == PBC_DONE);

	always_comb begin
		next_state = state;
		next_count = count_out;
		unique case (state)
			PBC_IDLE: begin
				if (gained) begin
					next_count = count_in; // R25
					next_state = (count_in == '0) ? PBC_DONE : PBC_RUN;
				end
			end
			PBC_RUN: begin
				if (!owner_in) begin
					next_state = PBC_IDLE;
				end else if (tick_in) begin
					next_count = count_out - WIDTH'(1); // R25
					if (count_out == WIDTH'(1)) begin
						next_state = PBC_DONE; // R25
					end
				end
			end
			PBC_DONE: begin
				if (!owner_in) begin
					next_state = PBC_IDLE;
				end
			end
			default: begin
				next_state = PBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state <= PBC_IDLE;
			count_out <= '0;
			owner_prev <= 1'b0;
		end else begin
			state <= next_state;
			count_out <= next_count;
			owner_prev <= owner_in;
		end
	end
endmodule : pbc_slice_timer
`default_nettype wire

/* File: hdl/pbc_sync.sv */
// Two-flop synchroniser for a group of level inputs
`default_nettype none
module pbc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : pbc_sync
`default_nettype wire

/* File: tb/pbc_monitor.sv */
// Checker for the PCI port configuration register bank
`default_nettype none
module pbc_monitor (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cfg_read_in,
	input wire logic cfg_write_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_byte_en_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic cfg_rvalid_out,
	input wire logic perr_n_out,
	input wire logic perr_n_oe_out,
	input wire logic serr_n_out,
	input wire logic serr_n_oe_out,
	input wire logic bus_owned_in,
	input wire logic data_phase_done_in,
	input wire logic slice_expired_out,
	input wire logic release_bus_out,
	input wire logic mwi_enable_out,
	input wire logic claim_io_out,
	input wire logic claim_special_out
);
	logic [8:0] cmd_q;
	wire logic cmd_wr = cfg_write_in && cfg_addr_in[7:2] == 6'h01;
	// Command copy to gate the pin checks
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cmd_q <= 9'h016;
		end else if (cmd_wr) begin
			if (cfg_byte_en_in[0]) cmd_q[7:0] <= cfg_wdata_in[7:0];
			if (cfg_byte_en_in[1]) cmd_q[8] <= cfg_wdata_in[8];
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	io_claim_a: assert property (!claim_io_out) else $error("io cycles claimed");
	special_claim_a: assert property (!claim_special_out) else $error("special cycles claimed");
	read_answer_a: assert property (cfg_read_in |=> cfg_rvalid_out) else $error("read not answered");
	answer_cause_a: assert property (cfg_rvalid_out |-> $past(cfg_read_in)) else $error("answer without read");
	rdata_hold_a: assert property (!cfg_read_in |=> $stable(cfg_rdata_out)) else $error("read data moved");
	parity_gate_a: assert property (!perr_n_oe_out |-> cmd_q[6]) else $error("perr driven while off");
	serr_gate_a: assert property (!serr_n_oe_out |-> cmd_q[6] && cmd_q[8]) else $error("serr gating");
	mwi_track_a: assert property (mwi_enable_out == cmd_q[4]) else $error("mwi enable wrong");
	release_cause_a: assert property (release_bus_out |-> slice_expired_out && data_phase_done_in)
		else $error("release without expiry");
	expiry_owned_a: assert property (!bus_owned_in [*2] |-> !slice_expired_out)
		else $error("expiry without ownership");
	pin_level_a: assert property (!perr_n_out && !serr_n_out) else $error("error pins not low");
	cover property ($fell(perr_n_oe_out));
	cover property ($fell(serr_n_oe_out));
	cover property ($rose(release_bus_out));
endmodule : pbc_monitor
bind pbc_config_regs pbc_monitor u_mon (.*);
`default_nettype wire

/* File: tb/pbc_pci_agent.sv */
// Model of the PCI bus agents on the far side of the port
`default_nettype none
module pbc_pci_agent (
	output logic pci_clk_out,
	output logic [6:0] events_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		pci_clk_out = 1'b0;
		events_out = 7'h00;
		forever #32 pci_clk_out = ~pci_clk_out;
	end
	// Held two PCI clocks so a rising edge sees it
	task automatic raise(input logic [6:0] ev);
		@(negedge pci_clk_out);
		events_out = ev;
		repeat (2) @(negedge pci_clk_out);
		events_out = 7'h00;
	endtask : raise
endmodule : pbc_pci_agent
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the PCI port configuration register bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in, rst_in, cfg_read_in, cfg_write_in, mode64_n_in, second_port_in, gnt_n_in;
	logic bus_owned_in, data_phase_done_in, clr_seen, perr_seen, serr_seen, pci_clk, cfg_rvalid_out;
	logic perr_n_out, perr_n_oe_out, serr_n_out, serr_n_oe_out, slice_expired_out, release_bus_out;
	logic mwi_enable_out, claim_io_out, claim_special_out, apic_hit_out, low_gap_hit_out, mapped_pci_hit_out;
	logic [7:0] legacy_space_window_out;
	logic [7:0] cfg_addr_in;
	logic [3:0] cfg_byte_en_in;
	logic [31:0] cfg_wdata_in, cfg_rdata_out, inbound_addr_in;
	logic [55:0] segment_attrs_out;
	logic [6:0] ev;
	int n_fail = 0;
	int num_checks = 0;
	logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h0c, 8'h54, 8'h60, 8'h64, 8'h68, 8'h70, 8'h78, 8'h7c, 8'h40};
	logic [31:0] rm [11] = '{32'hffffffff, 32'hffffffff, 32'h0000ff00, 32'hffffffff, 32'hffffff00,
		32'hffffffff, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h000000ff, 32'hffffffff};
	logic [31:0] re [11] = '{32'h3c4d1a2b, 32'h02800016, 32'h0, 32'h0, 32'h00000300, 32'h0, 32'h00000fec,
		32'h00000002, 32'h0, 32'h0, 32'h0};
	// Event bits: data par, addr par, master abort, special, abort rcvd, abort sent, initiator
	logic [15:0] ec [10] = '{16'h0, 16'h0, 16'h0140, 16'h0140, 16'h0100, 16'h0040, 16'h0140, 16'h0140,
		16'h0140, 16'h0140};
	logic [6:0] ee [10] = '{7'h41, 7'h02, 7'h41, 7'h02, 7'h02, 7'h01, 7'h04, 7'h0c, 7'h10, 7'h20};
	logic [15:0] es [10] = '{16'h8000, 16'h8000, 16'h8100, 16'hc000, 16'h8000, 16'h8000, 16'h2000, 16'h0,
		16'h1000, 16'h0800};
	logic [1:0] ep [10] = '{2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00};
	// Pull-up on PERR#
	wire logic perr_pin = perr_n_oe_out ? 1'b1 : perr_n_out;
	pbc_pci_agent agent (.pci_clk_out(pci_clk), .events_out(ev));
	// Identity values are arbitrary
	pbc_config_regs #(.VENDOR_IDENT(16'h1a2b), .DEVICE_IDENT(16'h3c4d)) dut (.*, .pci_clk_in(pci_clk),
		.data_parity_err_in(ev[0]), .addr_parity_err_in(ev[1]), .perr_n_in(perr_pin), .master_abort_in(ev[2]),
		.special_cycle_in(ev[3]), .target_abort_rcvd_in(ev[4]), .target_abort_sent_in(ev[5]), .initiator_in(ev[6]));
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		perr_seen <= !clr_seen && (perr_seen || perr_n_oe_out === 1'b0);
		serr_seen <= !clr_seen && (serr_seen || serr_n_oe_out === 1'b0);
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask : chk_bit
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge clock_in);
		cfg_write_in = 1'b1;
		cfg_addr_in = a;
		cfg_byte_en_in = be;
		cfg_wdata_in = d;
		@(negedge clock_in);
		cfg_write_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(negedge clock_in);
		cfg_read_in = 1'b1;
		cfg_addr_in = a;
		@(negedge clock_in);
		cfg_read_in = 1'b0;
		chk_bit(cfg_rvalid_out, 1'b1);
		chk_word(cfg_rdata_out & m, e);
	endtask : rd
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#50000;
		n_fail++;
		give_verdict();
	end
	initial begin
		{rst_in, mode64_n_in, clr_seen} = 3'b111;
		{cfg_read_in, cfg_write_in, second_port_in, gnt_n_in, bus_owned_in, data_phase_done_in} = 6'h0;
		{cfg_addr_in, cfg_byte_en_in, cfg_wdata_in, inbound_addr_in} = 76'h0;
		cyc(6);
		rst_in = 1'b0;
		cyc(2);
		for (int i = 0; i < 11; i++) rd(ra[i], rm[i], re[i]);
		chk_word(segment_attrs_out[31:0], 32'h03);
		$display("test done: reset values");
		wr(8'h04, 4'h3, 32'h0000ffff);
		rd(8'h04, 32'hffffffff, 32'h02800156);
		wr(8'h04, 4'h3, 32'h0);
		rd(8'h04, 32'hffffffff, 32'h02800006);
		chk_bit(mwi_enable_out, 1'b0);
		$display("test done: command");
		inbound_addr_in = 32'hfec00000;
		cyc(3);
		chk_bit(apic_hit_out, 1'b1);
		inbound_addr_in = 32'hfed00000;
		cyc(3);
		chk_bit(apic_hit_out, 1'b0);
		$display("test done: apic window");
		wr(8'h54, 4'hf, 32'h00200010);
		wr(8'h78, 4'h3, 32'h00000fff);
		wr(8'h7c, 4'h1, 32'h0000005a);
		inbound_addr_in = 32'h01800000;
		cyc(3);
		chk_word({21'h0, legacy_space_window_out, apic_hit_out, low_gap_hit_out, mapped_pci_hit_out}, 32'h2d3);
		$display("test done: decode windows");
		wr(8'h0c, 4'h2, 32'h0000ff00);
		rd(8'h0c, 32'h0000ff00, 32'h0000f800);
		wr(8'h0c, 4'h2, 32'h00000800);
		bus_owned_in = 1'b1;
		data_phase_done_in = 1'b1;
		cyc(70);
		chk_bit(slice_expired_out, 1'b0);
		cyc(60);
		chk_bit(slice_expired_out, 1'b1);
		chk_bit(release_bus_out, 1'b0);
		gnt_n_in = 1'b1;
		cyc(4);
		chk_bit(release_bus_out, 1'b1);
		bus_owned_in = 1'b0;
		cyc(3);
		chk_bit(slice_expired_out, 1'b0);
		$display("test done: time slice");
		for (int i = 0; i < 10; i++) begin
			wr(8'h04, 4'h3, {16'h0, ec[i]});
			clr_seen = 1'b1;
			cyc(1);
			clr_seen = 1'b0;
			agent.raise(ee[i]);
			cyc(8);
			chk_word({30'h0, perr_seen, serr_seen}, {30'h0, ep[i]});
			rd(8'h04, 32'hffffffff, {es[i] | 16'h0280, ec[i] & 16'h0150 | 16'h0006});
			wr(8'h04, 4'hc, 32'h0);
			rd(8'h04, 32'hffff0000, {es[i] | 16'h0280, 16'h0});
			wr(8'h04, 4'hc, 32'hffff0000);
			rd(8'h04, 32'hffff0000, 32'h02800000);
		end
		$display("test done: error events");
		{rst_in, mode64_n_in, second_port_in} = 3'b101;
		cyc(6);
		rst_in = 1'b0;
		cyc(2);
		rd(8'h04, 32'hffffffff, 32'h0);
		$display("test done: wide mode");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
